// *** hw/arseq_map.svh ***
/*
 Register offsets, field positions, reset values and timing counts of the
 recloser sequencer. Assumes a 250 MHz pclk and a 32-bit APB bus.
*/
`ifndef ARSEQ_MAP_SVH
`define ARSEQ_MAP_SVH

`define ARSEQ_CLK_MHZ        250
`define ARSEQ_TICK_US        1000
`define ARSEQ_TICK_CYC       (`ARSEQ_CLK_MHZ * `ARSEQ_TICK_US)

`define ARSEQ_OFF_CTRL       12'h000
`define ARSEQ_OFF_STATUS     12'h004
`define ARSEQ_OFF_EVENT      12'h008
`define ARSEQ_OFF_MASK       12'h00c
`define ARSEQ_OFF_START1     12'h010
`define ARSEQ_OFF_DEAD1      12'h014
`define ARSEQ_OFF_DEAD2      12'h018
`define ARSEQ_OFF_ARC1       12'h01c
`define ARSEQ_OFF_ARC2       12'h020
`define ARSEQ_OFF_RECLAIM    12'h024
`define ARSEQ_OFF_OVERALL    12'h028

`define ARSEQ_RST_START1     32'h0000_01f4
`define ARSEQ_RST_DEAD1      32'h0000_00c8
`define ARSEQ_RST_DEAD2      32'h0001_d4c0
`define ARSEQ_RST_ARC1       32'h0000_00c8
`define ARSEQ_RST_ARC2       32'h0000_00c8
`define ARSEQ_RST_RECLAIM    32'h0000_2710
`define ARSEQ_RST_OVERALL    32'h0000_2710

`define ARSEQ_CTRL_ENABLE    0
`define ARSEQ_CTRL_SHOT2_EN  1
`define ARSEQ_CTRL_OVR_USE   2
`define ARSEQ_CTRL_OVR_LOCK  3
`define ARSEQ_CTRL_RESET     4

`define ARSEQ_EV_OPEN        0
`define ARSEQ_EV_CLOSE       1
`define ARSEQ_EV_SHOT2       2
`define ARSEQ_EV_SUCCESS     3
`define ARSEQ_EV_LOCKOUT     4
`define ARSEQ_EV_READY       5
`define ARSEQ_EV_W           6

`endif

// *** hw/arseq_pkg.sv ***
/*
 Types of the recloser sequencer: states and the settings bundle.
 Assumes arseq_map.svh supplies the numbers.
*/
package arseq_pkg;

   typedef enum logic [3:0] {
      ST_READY, ST_START, ST_OPEN, ST_DEAD, ST_CLOSE, ST_RECLAIM,
      ST_OVERALL, ST_FINAL, ST_LOCKOUT
   } arseq_state_e;

   typedef struct packed {
      logic [31:0] start1;
      logic [31:0] dead1;
      logic [31:0] dead2;
      logic [31:0] arc1;
      logic [31:0] arc2;
      logic [31:0] reclaim;
      logic [31:0] overall;
   } arseq_cfg_s;

endpackage : arseq_pkg

// *** hw/arseq_top.sv ***
/*
 Auto-recloser shot sequencer with APB registers and one interrupt.
 Assumes request and breaker status inputs are synchronous to pclk, and that
 the breaker object forwards the close request only when its checks pass.
*/
`timescale 1ns/1ps
`default_nettype none
`include "arseq_map.svh"

module arseq_top (
   // APB
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Protection and breaker
   input  wire logic        request_one,
   input  wire logic        breaker_closed,
   input  wire logic        breaker_open,
   // Commands and status
   output logic             open_cmd,
   output logic             close_cmd,
   output logic             follower_open,
   output logic             follower_close_permit,
   output logic             request_one_active,
   output logic             recloser_running,
   output logic             first_shot_running,
   output logic             second_shot_running,
   output logic             overall_reclaim,
   output logic             lockout,
   output logic             irq
);

   typedef struct packed {
      arseq_pkg::arseq_state_e  st;
      arseq_pkg::arseq_cfg_s    cfg;
      logic [4:0]               ctrl;
      logic [`ARSEQ_EV_W-1:0]   ev;
      logic [`ARSEQ_EV_W-1:0]   mask;
      logic [17:0]              pre;
      logic                     tick;
      logic [31:0]              tmr;
      logic [31:0]              arc;
      logic                     shot2;
      logic                     req_act;
      logic                     running;
      logic                     f_open;
      logic                     f_permit;
      logic                     open_c;
      logic                     close_c;
      logic [31:0]              rdata;
   } arseq_reg_s;

   arseq_reg_s r_q;
   arseq_reg_s r_d;

   // Timer done: a zero setting counts as already expired
   function automatic logic tmr_done(input logic [31:0] cnt, input logic [31:0] set);
      tmr_done = (cnt >= set);
   endfunction : tmr_done

   logic                   wr_en;
   logic                   rd_en;
   logic                   addr_ok;
   logic [31:0]            rmux;
   logic [`ARSEQ_EV_W-1:0] ev_set;
   logic [31:0]            dead_set;
   logic [31:0]            arc_set;

   assign wr_en    = psel & penable & pwrite;
   assign rd_en    = psel & penable & ~pwrite;
   assign dead_set = r_q.shot2 ? r_q.cfg.dead2 : r_q.cfg.dead1;
   assign arc_set  = r_q.shot2 ? r_q.cfg.arc2 : r_q.cfg.arc1;

   always_comb begin
      addr_ok = 1'b1;
      rmux    = 32'h0000_0000;
      case (paddr)
         `ARSEQ_OFF_CTRL:    rmux = {27'h0, r_q.ctrl};
         `ARSEQ_OFF_STATUS:  rmux = {22'h0, r_q.st, lockout, r_q.f_permit, r_q.f_open,
                                     r_q.shot2, r_q.running, r_q.req_act};
         `ARSEQ_OFF_EVENT:   rmux = {26'h0, r_q.ev};
         `ARSEQ_OFF_MASK:    rmux = {26'h0, r_q.mask};
         `ARSEQ_OFF_START1:  rmux = r_q.cfg.start1;
         `ARSEQ_OFF_DEAD1:   rmux = r_q.cfg.dead1;
         `ARSEQ_OFF_DEAD2:   rmux = r_q.cfg.dead2;
         `ARSEQ_OFF_ARC1:    rmux = r_q.cfg.arc1;
         `ARSEQ_OFF_ARC2:    rmux = r_q.cfg.arc2;
         `ARSEQ_OFF_RECLAIM: rmux = r_q.cfg.reclaim;
         `ARSEQ_OFF_OVERALL: rmux = r_q.cfg.overall;
         default:            addr_ok = 1'b0;
      endcase
   end

   always_comb begin
      r_d    = r_q;
      ev_set = '0;
      r_d.ctrl[`ARSEQ_CTRL_RESET] = 1'b0;
      // 1 ms tick prescaler
      r_d.tick = (r_q.pre == 18'(`ARSEQ_TICK_CYC - 1));
      r_d.pre  = r_d.tick ? 18'h0_0000 : r_q.pre + 18'h0_0001;
      if (r_q.tick && r_q.tmr != 32'hffff_ffff) begin
         r_d.tmr = r_q.tmr + 32'h0000_0001;
      end

      case (r_q.st)
         arseq_pkg::ST_READY: begin
            r_d.tmr = 32'h0000_0000;
            r_d.arc = 32'h0000_0000;
            if (request_one && r_q.ctrl[`ARSEQ_CTRL_ENABLE]) begin
               r_d.st      = arseq_pkg::ST_START;
               r_d.req_act = 1'b1;
               r_d.shot2   = 1'b0;
            end
         end
         arseq_pkg::ST_START: begin
            if (!request_one) begin
               r_d.st      = arseq_pkg::ST_READY;
               r_d.req_act = 1'b0;
            end else if (tmr_done(r_q.tmr, r_q.cfg.start1)) begin
               r_d.st      = arseq_pkg::ST_OPEN;
               r_d.running = 1'b1;
               r_d.open_c  = 1'b1;
               r_d.f_open  = 1'b1;
               r_d.f_permit = 1'b0;
               ev_set[`ARSEQ_EV_OPEN] = 1'b1;
            end
         end
         arseq_pkg::ST_OPEN: begin
            if (breaker_open) begin
               r_d.open_c = 1'b0;
            end
            if (breaker_open && !request_one) begin
               r_d.st  = arseq_pkg::ST_DEAD;
               r_d.tmr = 32'h0000_0000;
            end
         end
         arseq_pkg::ST_DEAD: begin
            if (tmr_done(r_q.tmr, dead_set)) begin
               r_d.st      = arseq_pkg::ST_CLOSE;
               r_d.close_c = 1'b1;
               ev_set[`ARSEQ_EV_CLOSE] = 1'b1;
            end
         end
         arseq_pkg::ST_CLOSE: begin
            if (breaker_closed) begin
               r_d.close_c = 1'b0;
               r_d.st      = arseq_pkg::ST_RECLAIM;
               r_d.tmr     = 32'h0000_0000;
               r_d.arc     = 32'h0000_0000;
            end
         end
         arseq_pkg::ST_RECLAIM: begin
            // Arcing time is cumulative across pickups within one shot
            if (request_one && r_q.tick) begin
               r_d.arc = r_q.arc + 32'h0000_0001;
            end
            if (request_one && tmr_done(r_q.arc, arc_set)) begin
               if (!r_q.shot2 && r_q.ctrl[`ARSEQ_CTRL_SHOT2_EN]) begin
                  r_d.shot2  = 1'b1;
                  r_d.open_c = 1'b1;
                  r_d.st     = arseq_pkg::ST_OPEN;
                  ev_set[`ARSEQ_EV_SHOT2] = 1'b1;
                  ev_set[`ARSEQ_EV_OPEN]  = 1'b1;
               end else begin
                  r_d.st = arseq_pkg::ST_FINAL;
               end
            end else if (tmr_done(r_q.tmr, r_q.cfg.reclaim)) begin
               r_d.running = 1'b0;
               r_d.req_act = 1'b0;
               r_d.shot2   = 1'b0;
               r_d.tmr     = 32'h0000_0000;
               r_d.f_open  = 1'b0;
               r_d.f_permit = 1'b1;
               ev_set[`ARSEQ_EV_SUCCESS] = 1'b1;
               r_d.st = r_q.ctrl[`ARSEQ_CTRL_OVR_USE] ? arseq_pkg::ST_OVERALL
                                                      : arseq_pkg::ST_READY;
            end
         end
         arseq_pkg::ST_OVERALL: begin
            if (request_one && r_q.ctrl[`ARSEQ_CTRL_OVR_LOCK]) begin
               r_d.st = arseq_pkg::ST_FINAL;
            end else if (tmr_done(r_q.tmr, r_q.cfg.overall)) begin
               r_d.st = arseq_pkg::ST_READY;
               ev_set[`ARSEQ_EV_READY] = 1'b1;
            end
         end
         arseq_pkg::ST_FINAL: begin
            r_d.open_c   = 1'b1;
            r_d.running  = 1'b0;
            r_d.req_act  = 1'b0;
            r_d.shot2    = 1'b0;
            r_d.f_permit = 1'b0;
            r_d.st       = arseq_pkg::ST_LOCKOUT;
            ev_set[`ARSEQ_EV_LOCKOUT] = 1'b1;
         end
         arseq_pkg::ST_LOCKOUT: begin
            if (breaker_open) begin
               r_d.open_c = 1'b0;
            end
            if (r_q.ctrl[`ARSEQ_CTRL_RESET]) begin
               r_d.st     = arseq_pkg::ST_READY;
               r_d.f_open = 1'b0;
               r_d.open_c = 1'b0;
            end
         end
         default: r_d.st = arseq_pkg::ST_READY;
      endcase

      // Register writes; event bits cleared by a read, a new event wins
      if (wr_en) begin
         case (paddr)
            `ARSEQ_OFF_CTRL:    r_d.ctrl = pwdata[4:0];
            `ARSEQ_OFF_MASK:    r_d.mask = pwdata[`ARSEQ_EV_W-1:0];
            `ARSEQ_OFF_START1:  r_d.cfg.start1 = pwdata;
            `ARSEQ_OFF_DEAD1:   r_d.cfg.dead1 = pwdata;
            `ARSEQ_OFF_DEAD2:   r_d.cfg.dead2 = pwdata;
            `ARSEQ_OFF_ARC1:    r_d.cfg.arc1 = pwdata;
            `ARSEQ_OFF_ARC2:    r_d.cfg.arc2 = pwdata;
            `ARSEQ_OFF_RECLAIM: r_d.cfg.reclaim = pwdata;
            `ARSEQ_OFF_OVERALL: r_d.cfg.overall = pwdata;
            default:            ;
         endcase
      end
      if (rd_en && paddr == `ARSEQ_OFF_EVENT) begin
         // Clear only what the setup cycle reported, so a later event survives
         r_d.ev = (r_q.ev & ~r_q.rdata[`ARSEQ_EV_W-1:0]) | ev_set;
      end else begin
         r_d.ev = r_q.ev | ev_set;
      end
      // Read data is captured in the setup cycle and stands through the access
      r_d.rdata = (psel & ~penable & ~pwrite) ? rmux : 32'h0000_0000;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_q             <= '0;
         r_q.st          <= arseq_pkg::ST_READY;
         r_q.ctrl        <= 5'h07;
         r_q.cfg.start1  <= `ARSEQ_RST_START1;
         r_q.cfg.dead1   <= `ARSEQ_RST_DEAD1;
         r_q.cfg.dead2   <= `ARSEQ_RST_DEAD2;
         r_q.cfg.arc1    <= `ARSEQ_RST_ARC1;
         r_q.cfg.arc2    <= `ARSEQ_RST_ARC2;
         r_q.cfg.reclaim <= `ARSEQ_RST_RECLAIM;
         r_q.cfg.overall <= `ARSEQ_RST_OVERALL;
      end else begin
         r_q <= r_d;
      end
   end

   // Zero-wait slave: read data leaves a flip-flop loaded in the setup cycle
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;
   assign prdata  = r_q.rdata;

   assign open_cmd              = r_q.open_c;
   assign close_cmd             = r_q.close_c;
   assign follower_open         = r_q.f_open;
   assign follower_close_permit = r_q.f_permit;
   assign request_one_active    = r_q.req_act;
   assign recloser_running      = r_q.running;
   assign first_shot_running    = r_q.req_act & ~r_q.shot2;
   assign second_shot_running   = r_q.req_act & r_q.shot2;
   assign overall_reclaim       = (r_q.st == arseq_pkg::ST_OVERALL);
   assign lockout               = (r_q.st == arseq_pkg::ST_LOCKOUT);
   assign irq                   = |(r_q.ev & r_q.mask);

endmodule : arseq_top

`default_nettype wire

// *** verif/arseq_breaker.sv ***
/*
 Breaker object model facing the recloser: it changes state after a short or a
 long travel delay while a command is pending.
 Assumes commands are registered levels synchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none

module arseq_breaker (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Commands
   input  wire logic slow,
   input  wire logic open_cmd,
   input  wire logic close_cmd,
   // Status
   output logic      breaker_open,
   output logic      breaker_closed
);
   logic [5:0] cnt_q;

   // No travel state: the contacts are always either open or closed
   assign breaker_closed = !breaker_open;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q        <= 6'h00;
         breaker_open <= 1'b0;
      end else if ((open_cmd && !breaker_open) || (close_cmd && breaker_open)) begin
         cnt_q <= cnt_q + 6'h01;
         if (cnt_q == (slow ? 6'h28 : 6'h02)) begin
            cnt_q        <= 6'h00;
            breaker_open <= !breaker_open;
         end
      end else begin
         cnt_q <= 6'h00;
      end
   end
endmodule : arseq_breaker

`default_nettype wire

// *** verif/arseq_chk.sv ***
/*
 Port checker of the recloser sequencer.
 Assumes it is bound to arseq_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module arseq_chk (
   // Clock and APB
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic [11:0] paddr,
   input  wire logic        pready,
   input  wire logic        pslverr,
   // Breaker side
   input  wire logic        request_one,
   input  wire logic        breaker_open,
   input  wire logic        breaker_closed,
   input  wire logic        open_cmd,
   input  wire logic        close_cmd,
   input  wire logic        follower_open,
   input  wire logic        follower_close_permit,
   // Status
   input  wire logic        request_one_active,
   input  wire logic        recloser_running,
   input  wire logic        first_shot_running,
   input  wire logic        second_shot_running,
   input  wire logic        lockout
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   req_flags_a: assert property ($rose(request_one_active) |-> $past(request_one)
      && first_shot_running && !recloser_running) else $error("pickup flags wrong");
   run_open_a: assert property ($rose(recloser_running) |-> open_cmd)
      else $error("running without open command");
   open_hold_a: assert property (open_cmd && !breaker_open |=> open_cmd)
      else $error("open command dropped early");
   close_hold_a: assert property (close_cmd && !breaker_closed |=> close_cmd)
      else $error("close command dropped early");
   close_drop_a: assert property (close_cmd && breaker_closed |-> ##[1:2] !close_cmd)
      else $error("close command held after closed");
   no_clash_a: assert property (!(open_cmd && close_cmd))
      else $error("open and close together");
   shot_excl_a: assert property (!(first_shot_running && second_shot_running))
      else $error("both shots running");
   shot_move_a: assert property ($rose(second_shot_running) |-> open_cmd
      && $fell(first_shot_running)) else $error("shot two entered without open");
   follow_a: assert property (recloser_running |-> follower_open)
      else $error("follower not held open");
   permit_a: assert property (follower_close_permit |-> !recloser_running && !follower_open)
      else $error("permit during sequence");
   lock_hold_a: assert property (lockout |-> !close_cmd && !$rose(request_one_active))
      else $error("activity in lock-out");
   bad_addr_a: assert property (psel && penable && paddr > 12'h028 |-> pready && pslverr)
      else $error("unmapped access not refused");
endmodule : arseq_chk

bind arseq_top arseq_chk arseq_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .request_one(request_one), .breaker_open(breaker_open), .breaker_closed(breaker_closed),
   .open_cmd(open_cmd), .close_cmd(close_cmd), .follower_open(follower_open),
   .follower_close_permit(follower_close_permit), .request_one_active(request_one_active),
   .recloser_running(recloser_running), .first_shot_running(first_shot_running),
   .second_shot_running(second_shot_running), .lockout(lockout));

`default_nettype wire

// *** verif/tb_arseq_top.sv ***
/*
 Testbench of the recloser sequencer: APB master, pickup driver, breaker model.
 Assumes zero settings expire at once; no 1 ms tick is ever waited out.
*/
`timescale 1ns/1ps
`default_nettype none
`include "arseq_map.svh"

module tb_arseq_top;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, err, request_one = 1'b0, slow = 1'b0;
   logic        breaker_open, breaker_closed, open_cmd, close_cmd, follower_open;
   logic        follower_close_permit, request_one_active, recloser_running;
   logic        first_shot_running, second_shot_running, overall_reclaim, lockout, irq;
   int          miscompares = 0, comparisons = 0;
   wire logic [7:0] mon = {lockout, overall_reclaim, second_shot_running, breaker_closed,
                           breaker_open, close_cmd, open_cmd, recloser_running};

   always #2 pclk = ~pclk;

   arseq_top arseq_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .request_one(request_one), .breaker_closed(breaker_closed),
      .breaker_open(breaker_open), .open_cmd(open_cmd), .close_cmd(close_cmd),
      .follower_open(follower_open), .follower_close_permit(follower_close_permit),
      .request_one_active(request_one_active), .recloser_running(recloser_running),
      .first_shot_running(first_shot_running), .second_shot_running(second_shot_running),
      .overall_reclaim(overall_reclaim), .lockout(lockout), .irq(irq));
   arseq_breaker arseq_breaker_i (.pclk(pclk), .presetn(presetn), .slow(slow),
      .open_cmd(open_cmd), .close_cmd(close_cmd), .breaker_open(breaker_open),
      .breaker_closed(breaker_closed));

   task automatic conclude;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Bounded wait on one monitored output; running out ends the run
   task automatic wait_bit(input int b, input logic v);
      int n;
      n = 0;
      while (mon[b] !== v && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      chk(mon[b], v);
      if (n >= 3000) begin
         conclude();
      end
   endtask : wait_bit

   // Idle edge first so psel is never assigned twice in one step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(n < 50, 1'b1);
   endtask : apb

   task automatic shot(input logic again);
      wait_bit(1, 1'b1);
      wait_bit(3, 1'b1);
      request_one <= 1'b0;
      wait_bit(2, 1'b1);
      wait_bit(4, 1'b1);
      request_one <= again;
   endtask : shot

   task automatic t_regs;
      apb(1'b0, `ARSEQ_OFF_CTRL, 32'h0);
      chk(rd, 32'h7);
      apb(1'b0, `ARSEQ_OFF_START1, 32'h0);
      chk(rd, `ARSEQ_RST_START1);
      apb(1'b0, `ARSEQ_OFF_DEAD2, 32'h0);
      chk(rd, `ARSEQ_RST_DEAD2);
      apb(1'b0, `ARSEQ_OFF_RECLAIM, 32'h0);
      chk(rd, `ARSEQ_RST_RECLAIM);
      apb(1'b0, 12'h100, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      for (int a = 16; a <= 40; a += 4) begin
         apb(1'b1, a[11:0], 32'h0);
      end
      $display("test regs done");
   endtask : t_regs

   task automatic t_ok(input logic [31:0] ctrl);
      apb(1'b1, `ARSEQ_OFF_CTRL, ctrl);
      apb(1'b1, `ARSEQ_OFF_MASK, 32'h3f);
      request_one <= 1'b1;
      repeat (2) @(posedge pclk);
      chk({request_one_active, first_shot_running}, 2'b11);
      shot(1'b0);
      wait_bit(0, 1'b0);
      chk({follower_open, follower_close_permit}, 2'b01);
      chk(irq, 1'b1);
      apb(1'b0, `ARSEQ_OFF_STATUS, 32'h0);
      chk(rd[5:0], 6'h10);
      apb(1'b0, `ARSEQ_OFF_EVENT, 32'h0);
      chk(rd, ctrl[2] ? 32'h2b : 32'h0b);
      @(posedge pclk);
      chk({irq, overall_reclaim}, 2'b00);
      $display("test success cycle done");
   endtask : t_ok

   task automatic t_fail;
      apb(1'b1, `ARSEQ_OFF_RECLAIM, 32'h1);
      apb(1'b1, `ARSEQ_OFF_MASK, 32'h0);
      request_one <= 1'b1;
      shot(1'b1);
      wait_bit(5, 1'b1);
      chk({first_shot_running, open_cmd, follower_open}, 3'b011);
      shot(1'b1);
      wait_bit(7, 1'b1);
      chk(irq, 1'b0);
      apb(1'b1, `ARSEQ_OFF_MASK, 32'h10);
      @(posedge pclk);
      chk(irq, 1'b1);
      apb(1'b0, `ARSEQ_OFF_EVENT, 32'h0);
      chk(rd[5:0], 6'h17);
      request_one <= 1'b0;
      wait_bit(3, 1'b1);
      request_one <= 1'b1;
      repeat (2) @(posedge pclk);
      chk(request_one_active, 1'b0);
      request_one <= 1'b0;
      apb(1'b1, `ARSEQ_OFF_CTRL, 32'h17);
      wait_bit(7, 1'b0);
      apb(1'b1, `ARSEQ_OFF_RECLAIM, 32'h0);
      $display("test lock-out done");
   endtask : t_fail

   task automatic t_ovr;
      apb(1'b1, `ARSEQ_OFF_CTRL, 32'hf);
      apb(1'b1, `ARSEQ_OFF_OVERALL, 32'h1);
      request_one <= 1'b1;
      shot(1'b0);
      wait_bit(6, 1'b1);
      request_one <= 1'b1;
      wait_bit(7, 1'b1);
      request_one <= 1'b0;
      // Let the final open command complete before the manual reset
      wait_bit(3, 1'b1);
      apb(1'b1, `ARSEQ_OFF_CTRL, 32'h1f);
      wait_bit(7, 1'b0);
      $display("test overall reclaim fault done");
   endtask : t_ovr

   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_ok(32'h7);
      slow <= 1'b1;
      t_ok(32'h3);
      t_fail();
      t_ovr();
      conclude();
   end
endmodule : tb_arseq_top

`default_nettype wire
